/* rtl/virtual_segment_decoder.v */
// Virtual segment decoder: privilege mode, segment classification and fixed translation.
//
// Contract
// - User mode only when user bit set, both level bits clear, not debug.
// - Kernel mode when not debug and user bit clear or a level bit set.
// - Reset brings the processor up in kernel mode.
// - A non-debug exception sets exception or error level, entering kernel mode.
// - Exception return jumps to saved PC, clears error level if set, else exception level.
// - User mode addresses with bit 31 set raise an address error.
// - Translation-buffer variant tags user addresses with 8-bit space tag.
// - Fixed-map variant takes user cacheability from the user attribute field.
// - Kernel segment chosen from address bits 31..29 in ascending window order.
// - Cached kernel window is unmapped, physical is virtual minus its base.
// - Unmapped segments are uncached except cached window, which follows its field.
// - Uncached kernel window subtracts its base and disables caching.
// - With error level set, kernel user segment is identity, unmapped, uncached.
// - Mapped segments go to the translation buffer or fixed-map translator.
// - Fixed map uses the high kernel and user attributes, no write protection.
// - Kernel mode reaches all space and registers; user register access blockable.
// - Debug exception enters debug mode with kernel access plus the overlay.
// - Overlay decoding can be switched off, exposing the whole top window.
// - Debug overlay covers 0xff20_0000 through 0xff3f_ffff in debug mode.
`timescale 1ns/1ps
`include "segment_decoder_regs.vh"
module virtual_segment_decoder #(
  parameter FIXED_MAP = 0
) (
  input  wire        CLOCK_IN,
  input  wire        RESET_N_IN,
  input  wire        EXCEPTION_IN,
  input  wire        ERROR_EXCEPTION_IN,
  input  wire        DEBUG_EXCEPTION_IN,
  input  wire        DEBUG_RETURN_IN,
  input  wire        EXCEPTION_RETURN_OP_IN,
  input  wire [31:0] SAVED_PC_IN,
  input  wire        STATUS_WRITE_IN,
  input  wire        USER_MODE_BIT_IN,
  input  wire        EXCEPTION_LEVEL_BIT_IN,
  input  wire        ERROR_LEVEL_BIT_IN,
  input  wire        USER_CTRL_ENABLE_IN,
  input  wire        OVERLAY_ENABLE_IN,
  input  wire [2:0]  LOW_KERNEL_CACHE_ATTR_IN,
  input  wire [2:0]  HIGH_KERNEL_CACHE_ATTR_IN,
  input  wire [2:0]  USER_SEGMENT_CACHE_ATTR_IN,
  input  wire [7:0]  ADDRESS_SPACE_TAG_IN,
  input  wire        CTRL_ACCESS_IN,
  input  wire        ACCESS_VALID_IN,
  input  wire [31:0] VIRTUAL_ADDR_IN,
  output reg         ACCESS_VALID_OUT,
  output reg  [2:0]  SEGMENT_OUT,
  output reg         MAPPED_OUT,
  output reg  [31:0] PHYSICAL_ADDR_OUT,
  output reg  [7:0]  ADDRESS_SPACE_TAG_OUT,
  output reg         TAG_VALID_OUT,
  output reg  [2:0]  CACHE_ATTR_OUT,
  output reg         CACHE_FROM_PAGE_OUT,
  output reg         ADDRESS_ERROR_OUT,
  output reg         CTRL_ACCESS_ERROR_OUT,
  output reg  [1:0]  MODE_OUT,
  output reg         JUMP_OUT,
  output reg  [31:0] JUMP_TARGET_OUT
);
  wire       user_mode_bit;
  wire       exception_level_bit;
  wire       error_level_bit;
  wire       debug_mode_flag;
  wire [1:0] mode;

  privilege_state state_inst (
    .clk_in                    (CLOCK_IN),
    .reset_n_in                (RESET_N_IN),
    .exception_in              (EXCEPTION_IN),
    .error_exception_in        (ERROR_EXCEPTION_IN),
    .debug_exception_in        (DEBUG_EXCEPTION_IN),
    .debug_return_in           (DEBUG_RETURN_IN),
    .exception_return_op_in    (EXCEPTION_RETURN_OP_IN),
    .status_write_in           (STATUS_WRITE_IN),
    .user_mode_bit_wr_in       (USER_MODE_BIT_IN),
    .exception_level_bit_wr_in (EXCEPTION_LEVEL_BIT_IN),
    .error_level_bit_wr_in     (ERROR_LEVEL_BIT_IN),
    .user_mode_bit_out         (user_mode_bit),
    .exception_level_bit_out   (exception_level_bit),
    .error_level_bit_out       (error_level_bit),
    .debug_mode_flag_out       (debug_mode_flag),
    .mode_out                  (mode)
  );

  reg [2:0]  next_segment;
  reg        next_mapped;
  reg [31:0] next_physical;
  reg        next_tag_valid;
  reg [2:0]  next_cache_attr;
  reg        next_from_page;
  reg        next_addr_error;

  wire in_overlay = (VIRTUAL_ADDR_IN >= `OVERLAY_LO) &&
                    (VIRTUAL_ADDR_IN <= `OVERLAY_HI);

  // Mapped segments hand the virtual address on untouched; the translator replaces it.
  always @* begin
    next_segment    = `SEG_NONE;
    next_mapped     = 1'b0;
    next_physical   = VIRTUAL_ADDR_IN;
    next_tag_valid  = 1'b0;
    next_cache_attr = `CACHE_ATTR_UNCACHED;
    next_from_page  = 1'b0;
    next_addr_error = 1'b0;
    if (mode == `MODE_USER) begin
      if (VIRTUAL_ADDR_IN[31]) begin
        next_addr_error = 1'b1;
      end else begin
        next_segment = `SEG_USER;
        next_mapped  = 1'b1;
        if (FIXED_MAP != 0) begin
          next_cache_attr = USER_SEGMENT_CACHE_ATTR_IN;
        end else begin
          next_tag_valid = 1'b1;
          next_from_page = 1'b1;
        end
      end
    end else if (!VIRTUAL_ADDR_IN[31]) begin
      next_segment = `SEG_KERNEL_USER;
      if (!error_level_bit) begin
        next_mapped = 1'b1;
        if (FIXED_MAP != 0) begin
          next_cache_attr = USER_SEGMENT_CACHE_ATTR_IN;
        end else begin
          next_tag_valid = 1'b1;
          next_from_page = 1'b1;
        end
      end
      // Otherwise identity, unmapped, uncached and untagged.
    end else begin
      case (VIRTUAL_ADDR_IN[31:29])
        `KWIN_CACHED: begin
          next_segment    = `SEG_CACHED_KWIN;
          next_physical   = VIRTUAL_ADDR_IN - `CACHED_WIN_BASE;
          next_cache_attr = LOW_KERNEL_CACHE_ATTR_IN;
        end
        `KWIN_UNCACHED: begin
          next_segment  = `SEG_UNCACHED_KWIN;
          next_physical = VIRTUAL_ADDR_IN - `UNCACHED_WIN_BASE;
        end
        `KWIN_MAPPED_LOW: begin
          next_segment = `SEG_MAPPED_LOW;
          next_mapped  = 1'b1;
        end
        default: begin
          // Overlay wins only in debug mode and only while enabled.
          if (mode == `MODE_DEBUG && OVERLAY_ENABLE_IN && in_overlay) begin
            next_segment = `SEG_DEBUG_OVERLAY;
          end else begin
            next_segment = `SEG_MAPPED_HIGH;
            next_mapped  = 1'b1;
          end
        end
      endcase
      if (next_mapped) begin
        if (FIXED_MAP != 0) begin
          next_cache_attr = HIGH_KERNEL_CACHE_ATTR_IN;
        end else begin
          next_from_page = 1'b1;
        end
      end
    end
  end

  // Everything is registered, so a decode answers one cycle after the address.
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ACCESS_VALID_OUT      <= 1'b0;
      SEGMENT_OUT           <= `SEG_NONE;
      MAPPED_OUT            <= 1'b0;
      PHYSICAL_ADDR_OUT     <= 32'h0000_0000;
      ADDRESS_SPACE_TAG_OUT <= 8'h00;
      TAG_VALID_OUT         <= 1'b0;
      CACHE_ATTR_OUT        <= `CACHE_ATTR_UNCACHED;
      CACHE_FROM_PAGE_OUT   <= 1'b0;
      ADDRESS_ERROR_OUT     <= 1'b0;
      CTRL_ACCESS_ERROR_OUT <= 1'b0;
      MODE_OUT              <= `MODE_KERNEL;
      JUMP_OUT              <= 1'b0;
      JUMP_TARGET_OUT       <= 32'h0000_0000;
    end else begin
      ACCESS_VALID_OUT      <= ACCESS_VALID_IN;
      SEGMENT_OUT           <= next_segment;
      MAPPED_OUT            <= next_mapped;
      PHYSICAL_ADDR_OUT     <= next_physical;
      ADDRESS_SPACE_TAG_OUT <= next_tag_valid ? ADDRESS_SPACE_TAG_IN : 8'h00;
      TAG_VALID_OUT         <= next_tag_valid;
      CACHE_ATTR_OUT        <= next_cache_attr;
      CACHE_FROM_PAGE_OUT   <= next_from_page;
      ADDRESS_ERROR_OUT     <= ACCESS_VALID_IN && next_addr_error;
      CTRL_ACCESS_ERROR_OUT <= CTRL_ACCESS_IN && (mode == `MODE_USER) &&
                               !USER_CTRL_ENABLE_IN;
      MODE_OUT              <= mode;
      JUMP_OUT              <= EXCEPTION_RETURN_OP_IN;
      JUMP_TARGET_OUT       <= EXCEPTION_RETURN_OP_IN ? SAVED_PC_IN : JUMP_TARGET_OUT;
    end
  end
endmodule // virtual_segment_decoder

/* include/segment_decoder_regs.vh */
// Constants for the virtual segment decoder: windows, segment codes and attribute encodings.
`ifndef SEGMENT_DECODER_REGS_VH
`define SEGMENT_DECODER_REGS_VH
`define CACHED_WIN_BASE    32'h8000_0000
`define UNCACHED_WIN_BASE  32'ha000_0000
`define KWIN_CACHED        3'h4
`define KWIN_UNCACHED      3'h5
`define KWIN_MAPPED_LOW    3'h6
`define KWIN_MAPPED_HIGH   3'h7
`define OVERLAY_LO         32'hff20_0000
`define OVERLAY_HI         32'hff3f_ffff
`define SEG_USER           3'h0
`define SEG_KERNEL_USER    3'h1
`define SEG_CACHED_KWIN    3'h2
`define SEG_UNCACHED_KWIN  3'h3
`define SEG_MAPPED_LOW     3'h4
`define SEG_MAPPED_HIGH    3'h5
`define SEG_DEBUG_OVERLAY  3'h6
`define SEG_NONE           3'h7
`define MODE_KERNEL        2'h0
`define MODE_USER          2'h1
`define MODE_DEBUG         2'h2
`define CACHE_ATTR_UNCACHED 3'h2
`define ADDR_TAG_WIDTH     8
`endif

/* rtl/privilege_state.v */
// Privilege state holder: status level bits, debug flag and derived operating mode.
`timescale 1ns/1ps
`include "segment_decoder_regs.vh"
module privilege_state (
  input  wire       clk_in,
  input  wire       reset_n_in,
  input  wire       exception_in,
  input  wire       error_exception_in,
  input  wire       debug_exception_in,
  input  wire       debug_return_in,
  input  wire       exception_return_op_in,
  input  wire       status_write_in,
  input  wire       user_mode_bit_wr_in,
  input  wire       exception_level_bit_wr_in,
  input  wire       error_level_bit_wr_in,
  output reg        user_mode_bit_out,
  output reg        exception_level_bit_out,
  output reg        error_level_bit_out,
  output reg        debug_mode_flag_out,
  output wire [1:0] mode_out
);
  // Reset lands with error level set, so the core starts in kernel mode.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      user_mode_bit_out       <= 1'b0;
      exception_level_bit_out <= 1'b0;
      error_level_bit_out     <= 1'b1;
      debug_mode_flag_out     <= 1'b0;
    end else begin
      if (status_write_in) begin
        user_mode_bit_out       <= user_mode_bit_wr_in;
        exception_level_bit_out <= exception_level_bit_wr_in;
        error_level_bit_out     <= error_level_bit_wr_in;
      end
      // Exceptions take priority over a status write in the same cycle.
      if (error_exception_in) begin
        error_level_bit_out <= 1'b1;
      end else if (exception_in) begin
        exception_level_bit_out <= 1'b1;
      end else if (exception_return_op_in) begin
        error_level_bit_out <= 1'b0;
        if (!error_level_bit_out) begin
          exception_level_bit_out <= 1'b0;
        end
      end
      if (debug_exception_in) begin
        debug_mode_flag_out <= 1'b1;
      end else if (debug_return_in) begin
        debug_mode_flag_out <= 1'b0;
      end
    end
  end

  assign mode_out = debug_mode_flag_out ? `MODE_DEBUG :
                    (user_mode_bit_out && !exception_level_bit_out &&
                     !error_level_bit_out) ? `MODE_USER : `MODE_KERNEL;
endmodule // privilege_state

/* tb/segment_decoder_chk.sv */
// Port-level assertion checker for the virtual segment decoder.
`timescale 1ns/1ps
`include "segment_decoder_regs.vh"
module segment_decoder_chk (
  input wire        CLOCK_IN,
  input wire        RESET_N_IN,
  input wire        EXCEPTION_IN,
  input wire        ERROR_EXCEPTION_IN,
  input wire        DEBUG_EXCEPTION_IN,
  input wire        EXCEPTION_RETURN_OP_IN,
  input wire        USER_CTRL_ENABLE_IN,
  input wire        OVERLAY_ENABLE_IN,
  input wire        CTRL_ACCESS_IN,
  input wire        ACCESS_VALID_IN,
  input wire        ACCESS_VALID_OUT,
  input wire        MAPPED_OUT,
  input wire        ADDRESS_ERROR_OUT,
  input wire        CTRL_ACCESS_ERROR_OUT,
  input wire        JUMP_OUT,
  input wire [31:0] SAVED_PC_IN,
  input wire [31:0] VIRTUAL_ADDR_IN,
  input wire [31:0] PHYSICAL_ADDR_OUT,
  input wire [31:0] JUMP_TARGET_OUT,
  input wire [2:0]  LOW_KERNEL_CACHE_ATTR_IN,
  input wire [2:0]  SEGMENT_OUT,
  input wire [2:0]  CACHE_ATTR_OUT,
  input wire [1:0]  MODE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence ret_taken;
    EXCEPTION_RETURN_OP_IN && !EXCEPTION_IN && !ERROR_EXCEPTION_IN;
  endsequence
  sequence enter_kernel;
    ##2 MODE_OUT == `MODE_KERNEL;
  endsequence
  a_reset_kernel: assert property (
    $rose(RESET_N_IN) |-> MODE_OUT == `MODE_KERNEL) else $error("not kernel after reset");
  a_exc_kernel: assert property (
    (EXCEPTION_IN || ERROR_EXCEPTION_IN) && !DEBUG_EXCEPTION_IN && MODE_OUT != `MODE_DEBUG
      |-> enter_kernel)
    else $error("exception did not enter kernel mode");
  a_return_jump: assert property (
    ret_taken |=> JUMP_OUT && JUMP_TARGET_OUT == $past(SAVED_PC_IN))
    else $error("return did not jump to saved pc");
  a_user_error: assert property (
    ADDRESS_ERROR_OUT |-> ACCESS_VALID_OUT && SEGMENT_OUT == `SEG_NONE
      && $past(VIRTUAL_ADDR_IN[31])) else $error("address error without upper address");
  a_user_seg: assert property (
    ACCESS_VALID_OUT && SEGMENT_OUT == `SEG_USER |-> MAPPED_OUT && !$past(VIRTUAL_ADDR_IN[31]))
    else $error("user segment decode wrong");
  a_cached_win: assert property (
    ACCESS_VALID_OUT && SEGMENT_OUT == `SEG_CACHED_KWIN |-> !MAPPED_OUT
      && PHYSICAL_ADDR_OUT == $past(VIRTUAL_ADDR_IN) - `CACHED_WIN_BASE
      && CACHE_ATTR_OUT == $past(LOW_KERNEL_CACHE_ATTR_IN)) else $error("cached window wrong");
  a_uncached_win: assert property (
    ACCESS_VALID_OUT && SEGMENT_OUT == `SEG_UNCACHED_KWIN |-> !MAPPED_OUT
      && PHYSICAL_ADDR_OUT == $past(VIRTUAL_ADDR_IN) - `UNCACHED_WIN_BASE
      && CACHE_ATTR_OUT == `CACHE_ATTR_UNCACHED) else $error("uncached window wrong");
  a_mapped_high: assert property (
    ACCESS_VALID_OUT && SEGMENT_OUT inside {`SEG_MAPPED_LOW, `SEG_MAPPED_HIGH} |-> MAPPED_OUT
      && $past(VIRTUAL_ADDR_IN[31:30]) == 2'b11) else $error("mapped window wrong");
  a_overlay_range: assert property (
    ACCESS_VALID_OUT && SEGMENT_OUT == `SEG_DEBUG_OVERLAY |-> $past(OVERLAY_ENABLE_IN)
      && $past(VIRTUAL_ADDR_IN) inside {[`OVERLAY_LO:`OVERLAY_HI]})
    else $error("overlay decoded outside its range");
  // The mode output lags the decode by the same cycle as the refusal, so both line up.
  a_ctrl_block: assert property (
    CTRL_ACCESS_ERROR_OUT |-> MODE_OUT == `MODE_USER && $past(CTRL_ACCESS_IN)
      && !$past(USER_CTRL_ENABLE_IN))
    else $error("control access refused without cause");
endmodule // segment_decoder_chk
bind virtual_segment_decoder segment_decoder_chk chk (.CLOCK_IN, .RESET_N_IN, .EXCEPTION_IN,
  .ERROR_EXCEPTION_IN, .DEBUG_EXCEPTION_IN, .EXCEPTION_RETURN_OP_IN, .USER_CTRL_ENABLE_IN,
  .OVERLAY_ENABLE_IN, .CTRL_ACCESS_IN, .ACCESS_VALID_IN, .ACCESS_VALID_OUT, .MAPPED_OUT,
  .ADDRESS_ERROR_OUT, .CTRL_ACCESS_ERROR_OUT, .JUMP_OUT, .SAVED_PC_IN, .VIRTUAL_ADDR_IN,
  .PHYSICAL_ADDR_OUT, .JUMP_TARGET_OUT, .LOW_KERNEL_CACHE_ATTR_IN, .SEGMENT_OUT,
  .CACHE_ATTR_OUT, .MODE_OUT);

/* tb/access_source.sv */
// Pipeline-side model that issues one virtual address access at a time.
`timescale 1ns/1ps
module access_source (
  input  wire        clk_in,
  output reg         valid_out = 1'b0,
  output reg  [31:0] addr_out = 32'h0
);
  // Between accesses the address is inverted, so a stale value cannot pass for a live one.
  task send(input [31:0] a);
    begin
      @(posedge clk_in) #1;
      valid_out = 1'b1;
      addr_out = a;
      @(posedge clk_in) #1;
      valid_out = 1'b0;
      addr_out = ~a;
    end
  endtask
endmodule // access_source

/* tb/tb_virtual_segment_decoder.sv */
// Self-checking testbench for the virtual segment decoder.
`timescale 1ns/1ps
`include "segment_decoder_regs.vh"
module tb_virtual_segment_decoder;
  reg         clk = 1'b0, rst_n = 1'b0, ctrl = 1'b0, ovl = 1'b1, uctl = 1'b0;
  reg  [2:0]  st = 3'h0;
  reg  [5:0]  ev = 6'h0;
  reg  [31:0] saved_pc = 32'h0000_0400;
  wire        avalid, mapped, err, cerr, tagv, avo, cfp, jump;
  wire [31:0] va, pa, jtgt;
  wire [7:0]  tag;
  wire [2:0]  seg, attr;
  wire [1:0]  mode;
  integer     mismatches = 0, samples_checked = 0;
  always #2 clk = ~clk;
  access_source src (.clk_in(clk), .valid_out(avalid), .addr_out(va));
  virtual_segment_decoder uut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .EXCEPTION_IN(ev[0]),
    .ERROR_EXCEPTION_IN(ev[5]), .DEBUG_EXCEPTION_IN(ev[1]), .DEBUG_RETURN_IN(ev[2]),
    .EXCEPTION_RETURN_OP_IN(ev[3]), .SAVED_PC_IN(saved_pc), .STATUS_WRITE_IN(ev[4]),
    .USER_MODE_BIT_IN(st[0]), .EXCEPTION_LEVEL_BIT_IN(st[1]), .ERROR_LEVEL_BIT_IN(st[2]),
    .USER_CTRL_ENABLE_IN(uctl), .OVERLAY_ENABLE_IN(ovl), .LOW_KERNEL_CACHE_ATTR_IN(3'h3),
    .HIGH_KERNEL_CACHE_ATTR_IN(3'h5), .USER_SEGMENT_CACHE_ATTR_IN(3'h1),
    .ADDRESS_SPACE_TAG_IN(8'h5a), .CTRL_ACCESS_IN(ctrl), .ACCESS_VALID_IN(avalid),
    .VIRTUAL_ADDR_IN(va), .ACCESS_VALID_OUT(avo), .SEGMENT_OUT(seg), .MAPPED_OUT(mapped),
    .PHYSICAL_ADDR_OUT(pa), .ADDRESS_SPACE_TAG_OUT(tag), .TAG_VALID_OUT(tagv),
    .CACHE_ATTR_OUT(attr), .CACHE_FROM_PAGE_OUT(cfp), .ADDRESS_ERROR_OUT(err),
    .CTRL_ACCESS_ERROR_OUT(cerr), .MODE_OUT(mode), .JUMP_OUT(jump), .JUMP_TARGET_OUT(jtgt));
  task chk(input [8*10-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (exp !== got) begin
        mismatches = mismatches + 1;
        $display("unexpected %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Mode changes show two cycles after the event edge, so the check waits that long.
  task pulse(input [5:0] p, input [1:0] m);
    begin
      @(posedge clk) #1 ev = p;
      @(posedge clk) #1 ev = 6'h0;
      chk("jump", p[3], jump);
      if (p[3]) chk("target", saved_pc, jtgt);
      repeat (2) @(posedge clk);
      #1 chk("mode", m, mode);
    end
  endtask
  // Mapped segments take their cacheability from the page entry in this variant.
  task acc(input [31:0] a, input [2:0] s, input [31:0] p, input [2:0] c, input m);
    begin
      src.send(a);
      chk("valid", 1'b1, avo);
      chk("segment", s, seg);
      chk("phys", p, pa);
      chk("mapped", m, mapped);
      chk("from page", m, cfp);
      if (!m) chk("attr", c, attr);
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d mismatched %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #20000 mismatches = mismatches + 1;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("mode", `MODE_KERNEL, mode);
    acc(32'h0000_1000, `SEG_KERNEL_USER, 32'h0000_1000, `CACHE_ATTR_UNCACHED, 0);
    acc(32'h8000_1234, `SEG_CACHED_KWIN, 32'h0000_1234, 3'h3, 0);
    acc(32'hbfff_fffc, `SEG_UNCACHED_KWIN, 32'h1fff_fffc, `CACHE_ATTR_UNCACHED, 0);
    acc(32'hc000_0040, `SEG_MAPPED_LOW, 32'hc000_0040, 3'h0, 1);
    acc(32'hff20_0000, `SEG_MAPPED_HIGH, 32'hff20_0000, 3'h0, 1);
    $display("kernel decode done");
    st = 3'b001;
    pulse(6'h10, `MODE_USER);
    acc(32'h7fff_fff0, `SEG_USER, 32'h7fff_fff0, 3'h0, 1);
    chk("tag", 8'h5a, tag);
    chk("tag valid", 1'b1, tagv);
    ctrl = 1'b1;
    src.send(32'h8000_0000);
    chk("addr err", 1'b1, err);
    chk("segment", `SEG_NONE, seg);
    chk("ctrl err", 1'b1, cerr);
    uctl = 1'b1;
    src.send(32'h0000_0100);
    ctrl = 1'b0;
    chk("addr err", 1'b0, err);
    chk("ctrl err", 1'b0, cerr);
    $display("user mode done");
    pulse(6'h01, `MODE_KERNEL);
    acc(32'h0000_3000, `SEG_KERNEL_USER, 32'h0000_3000, 3'h0, 1);
    chk("tag valid", 1'b1, tagv);
    saved_pc = 32'h0000_0180;
    pulse(6'h08, `MODE_USER);
    pulse(6'h20, `MODE_KERNEL);
    acc(32'h0000_2000, `SEG_KERNEL_USER, 32'h0000_2000, `CACHE_ATTR_UNCACHED, 0);
    chk("tag valid", 1'b0, tagv);
    $display("exceptions done");
    pulse(6'h02, `MODE_DEBUG);
    acc(32'hff1f_fffc, `SEG_MAPPED_HIGH, 32'hff1f_fffc, 3'h0, 1);
    acc(32'hff20_0000, `SEG_DEBUG_OVERLAY, 32'hff20_0000, `CACHE_ATTR_UNCACHED, 0);
    ovl = 1'b0;
    acc(32'hff3f_fffc, `SEG_MAPPED_HIGH, 32'hff3f_fffc, 3'h0, 1);
    pulse(6'h04, `MODE_KERNEL);
    $display("debug mode done");
    // A reset in mid-run from user mode must land back in kernel mode.
    pulse(6'h10, `MODE_USER);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("mode", `MODE_KERNEL, mode);
    acc(32'h0000_4000, `SEG_KERNEL_USER, 32'h0000_4000, `CACHE_ATTR_UNCACHED, 0);
    $display("reset test done");
    print_verdict;
  end
endmodule // tb_virtual_segment_decoder
